/* File: rtl/ofd_params.svh */
/*
 Constants for the upper-group opcode field decoder: field positions,
 pattern codes and fixed values.
 Assumes it is included by bare name by the decoder.
*/
`ifndef OFD_PARAMS_SVH
`define OFD_PARAMS_SVH
`define OFD_GRP_HI       15
`define OFD_GRP_LO       12
`define OFD_COND_HI      11
`define OFD_COND_LO      8
`define OFD_REGX_HI      11
`define OFD_REGX_LO      9
`define OFD_OPM_HI       8
`define OFD_OPM_LO       6
`define OFD_SIZE_HI      7
`define OFD_SIZE_LO      6
`define OFD_RM_BIT       3
`define OFD_REGY_HI      2
`define OFD_REGY_LO      0
`define OFD_GRP_QUICK    4'h5
`define OFD_GRP_BRANCH   4'h6
`define OFD_GRP_MOVE_QUICK    4'h7
`define OFD_GRP_OR       4'h8
`define OFD_GRP_SUB      4'h9
`define OFD_GRP_CMP      4'hB
`define OFD_GRP_AND      4'hC
`define OFD_TRAP_ONES    5'h1F
`define OFD_TRAP_WORD    3'h2
`define OFD_TRAP_LONG    3'h3
`define OFD_TRAP_NONE    3'h4
`define OFD_DISP_EXT16   8'h00
`define OFD_DISP_EXT32   8'hFF
`define OFD_SIZE_BYTE    2'h0
`define OFD_SIZE_WORD    2'h1
`define OFD_SIZE_LONG    2'h2
`define OFD_SIZE_BAD     2'h3
`define OFD_QUICK_EIGHT  4'h8
`endif

/* File: rtl/ofd_pkg.sv */
/*
 Types shared by the upper-group opcode decoder.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package ofd_pkg;
	typedef enum logic [4:0] {
		OFD_OP_NONE, OFD_OP_TRAP, OFD_OP_SUBTRACT_QUICK, OFD_OP_BCC, OFD_OP_BRA, OFD_OP_BSR,
		OFD_OP_MOVE_QUICK, OFD_OP_OR, OFD_OP_UNSIGNED_DIVIDE, OFD_OP_SIGNED_DIVIDE, OFD_OP_DECIMAL_SUBTRACT_EXTEND, OFD_OP_SUB,
		OFD_OP_SUBA, OFD_OP_SUBTRACT_EXTEND, OFD_OP_CMP, OFD_OP_CMPA, OFD_OP_EOR, OFD_OP_COMPARE_MEMORY,
		OFD_OP_AND
	} ofd_op_e;
	typedef enum logic [1:0] {OFD_EXT_NONE, OFD_EXT_WORD, OFD_EXT_LONG} ofd_ext_e;
	typedef enum {OFD_ST_IDLE, OFD_ST_EXT_HI, OFD_ST_EXT_LO} ofd_state_e;
endpackage

/* File: rtl/ofd_decoder.sv */
/*
 Upper-group opcode field decoder: takes the first opcode word from the
 prefetch queue, decodes it, then takes any extension words.
 Assumes the queue presents words with a valid/ready handshake and the
 datapath consumes one registered decode pulse per instruction.
*/
// What this block does
// - Conditional trap is group 0101 with a condition in bits 11..8 and ones in bits 7..3.
// - Conditional trap opmode 010 takes one word, 011 a long and 100 no extension.
// - Quick subtract immediate 1 to 7 means itself and 0 means eight.
// - Quick subtract size 00 is byte, 01 word and 10 long.
// - Branches with displacement 00 hex take a 16-bit word and with FF hex a 32-bit displacement.
// - Quick move sign-extends its 8-bit immediate to 32 bits for the data register.
// - Word divide type bit 0 means unsigned and 1 signed.
// - Decimal subtract with operand bit 0 uses data registers, 1 predecrement address registers.
// - Subtract extend with operand bit 0 is register to register, 1 memory to memory by predecrement.
// - Subtract extend and compare memory size 00 is byte, 01 word and 10 long.
`timescale 1ns/100ps
`include "ofd_params.svh"
module ofd_decoder (
	// clock and reset
	input  wire logic           ref_clk,
	input  wire logic           rst,
	// prefetch queue
	input  wire logic           iw_valid,
	input  wire logic [15:0]    iw_data,
	output logic                iw_ready,
	// decoded instruction
	output logic                dec_valid,
	output ofd_pkg::ofd_op_e    dec_op,
	output logic [1:0]          dec_size,
	output logic [2:0]          dec_reg_x,
	output logic [2:0]          dec_reg_y,
	output logic [3:0]          dec_cond,
	output logic                dec_to_ea,
	output logic                dec_mem_mode,
	output logic [31:0]         dec_imm,
	output logic [31:0]         dec_ext,
	output logic                dec_illegal
);
	ofd_pkg::ofd_state_e state;
	ofd_pkg::ofd_state_e next_state;
	logic [15:0] opw;
	logic [15:0] ext_hi;

	// size field check, used only for quick subtract
	function automatic logic size_ok(input logic [1:0] s);
		size_ok = (s != `OFD_SIZE_BAD);
	endfunction

	// field extraction
	wire logic [3:0] grp   = iw_data[`OFD_GRP_HI:`OFD_GRP_LO];
	wire logic [2:0] opm   = iw_data[`OFD_OPM_HI:`OFD_OPM_LO];
	wire logic [1:0] sz    = iw_data[`OFD_SIZE_HI:`OFD_SIZE_LO];
	wire logic [7:0] disp8 = iw_data[7:0];
	wire logic [2:0] qdat  = iw_data[`OFD_REGX_HI:`OFD_REGX_LO];
	wire logic       rm    = iw_data[`OFD_RM_BIT];
	wire logic       b8    = iw_data[8];
	wire logic       xform = (iw_data[5:4] == 2'h0); // register/memory pair forms
	wire logic       is_trap = (grp == `OFD_GRP_QUICK) && (iw_data[7:3] == `OFD_TRAP_ONES);
	wire logic       trap_ok = (iw_data[2:0] == `OFD_TRAP_WORD) || (iw_data[2:0] == `OFD_TRAP_LONG)
		|| (iw_data[2:0] == `OFD_TRAP_NONE);

	// opcode classification
	ofd_pkg::ofd_op_e c_op;
	logic             c_ill;
	ofd_pkg::ofd_ext_e c_ext;
	always_comb begin
		c_op  = ofd_pkg::OFD_OP_NONE;
		c_ill = 1'b0;
		c_ext = ofd_pkg::OFD_EXT_NONE;
		case (grp)
			`OFD_GRP_QUICK: begin
				if (is_trap) begin
					c_op  = ofd_pkg::OFD_OP_TRAP;
					c_ill = !trap_ok;
					c_ext = (iw_data[2:0] == `OFD_TRAP_WORD) ? ofd_pkg::OFD_EXT_WORD :
						(iw_data[2:0] == `OFD_TRAP_LONG) ? ofd_pkg::OFD_EXT_LONG : ofd_pkg::OFD_EXT_NONE;
				end else if (b8 && size_ok(sz)) begin
					c_op = ofd_pkg::OFD_OP_SUBTRACT_QUICK;
				end else begin
					c_ill = 1'b1; // outside this block's range or bad size
				end
			end
			`OFD_GRP_BRANCH: begin
				c_op  = (iw_data[11:8] == 4'h0) ? ofd_pkg::OFD_OP_BRA :
					(iw_data[11:8] == 4'h1) ? ofd_pkg::OFD_OP_BSR : ofd_pkg::OFD_OP_BCC;
				c_ext = (disp8 == `OFD_DISP_EXT16) ? ofd_pkg::OFD_EXT_WORD :
					(disp8 == `OFD_DISP_EXT32) ? ofd_pkg::OFD_EXT_LONG : ofd_pkg::OFD_EXT_NONE;
			end
			`OFD_GRP_MOVE_QUICK: begin
				c_op  = ofd_pkg::OFD_OP_MOVE_QUICK;
				c_ill = b8;
			end
			`OFD_GRP_OR: begin
				if (opm[1:0] == 2'h3) c_op = b8 ? ofd_pkg::OFD_OP_SIGNED_DIVIDE : ofd_pkg::OFD_OP_UNSIGNED_DIVIDE;
				else if (b8 && xform) c_op = ofd_pkg::OFD_OP_DECIMAL_SUBTRACT_EXTEND;
				else c_op = ofd_pkg::OFD_OP_OR;
				c_ill = (opm[1:0] != 2'h3) && b8 && xform && (sz != `OFD_SIZE_BYTE);
			end
			`OFD_GRP_SUB: begin
				if (opm[1:0] == 2'h3) c_op = ofd_pkg::OFD_OP_SUBA;
				else if (b8 && xform) c_op = ofd_pkg::OFD_OP_SUBTRACT_EXTEND;
				else c_op = ofd_pkg::OFD_OP_SUB;
			end
			`OFD_GRP_CMP: begin
				if (opm[1:0] == 2'h3) c_op = ofd_pkg::OFD_OP_CMPA;
				else if (!b8) c_op = ofd_pkg::OFD_OP_CMP;
				else if (iw_data[5:3] == 3'h1) c_op = ofd_pkg::OFD_OP_COMPARE_MEMORY;
				else c_op = ofd_pkg::OFD_OP_EOR;
			end
			`OFD_GRP_AND: begin
				c_op  = ofd_pkg::OFD_OP_AND;
				c_ill = (opm[1:0] == 2'h3) || (b8 && xform); // multiply and pair forms lie outside
			end
			default: c_ill = 1'b1;
		endcase
	end

	// immediate value: quick subtract 0 means eight, quick move sign-extends
	wire logic [31:0] c_imm = (grp == `OFD_GRP_MOVE_QUICK) ? {{24{disp8[7]}}, disp8} :
		(qdat == 3'h0) ? {28'h0, `OFD_QUICK_EIGHT} : {29'h0, qdat};
	wire logic [1:0] c_size = (grp == `OFD_GRP_BRANCH || grp == `OFD_GRP_MOVE_QUICK) ? `OFD_SIZE_LONG :
		(opm[1:0] == 2'h3) ? (b8 ? `OFD_SIZE_LONG : `OFD_SIZE_WORD) : sz;
	wire logic        take_op  = (state == ofd_pkg::OFD_ST_IDLE) && iw_valid;
	wire logic        take_ext = (state != ofd_pkg::OFD_ST_IDLE) && iw_valid;

	// one word is taken per cycle; the queue is never stalled
	assign iw_ready = 1'b1;

	// sequencer for extension words
	always_comb begin
		next_state = state;
		case (state)
			ofd_pkg::OFD_ST_IDLE: if (take_op && !c_ill) begin
				if (c_ext == ofd_pkg::OFD_EXT_LONG) next_state = ofd_pkg::OFD_ST_EXT_HI;
				else if (c_ext == ofd_pkg::OFD_EXT_WORD) next_state = ofd_pkg::OFD_ST_EXT_LO;
			end
			ofd_pkg::OFD_ST_EXT_HI: if (take_ext) next_state = ofd_pkg::OFD_ST_EXT_LO;
			ofd_pkg::OFD_ST_EXT_LO: if (take_ext) next_state = ofd_pkg::OFD_ST_IDLE;
			default: next_state = ofd_pkg::OFD_ST_IDLE;
		endcase
	end

	wire logic done = (take_op && (c_ill || c_ext == ofd_pkg::OFD_EXT_NONE)) ||
		(take_ext && state == ofd_pkg::OFD_ST_EXT_LO);

	// state and captured opcode fields
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			state <= ofd_pkg::OFD_ST_IDLE;
			opw <= 16'h0000;
			ext_hi <= 16'h0000;
		end else begin
			state <= next_state;
			if (take_op) opw <= iw_data;
			if (take_ext && state == ofd_pkg::OFD_ST_EXT_HI) ext_hi <= iw_data;
		end
	end

	// registered decode outputs
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			dec_valid <= 1'b0;
			dec_op <= ofd_pkg::OFD_OP_NONE;
			dec_size <= `OFD_SIZE_BYTE;
			dec_reg_x <= 3'h0;
			dec_reg_y <= 3'h0;
			dec_cond <= 4'h0;
			dec_to_ea <= 1'b0;
			dec_mem_mode <= 1'b0;
			dec_imm <= 32'h0000_0000;
			dec_ext <= 32'h0000_0000;
			dec_illegal <= 1'b0;
		end else begin
			dec_valid <= done;
			if (take_op) begin
				dec_op <= c_op;
				dec_size <= c_size;
				dec_reg_x <= qdat;
				dec_reg_y <= iw_data[`OFD_REGY_HI:`OFD_REGY_LO];
				dec_cond <= iw_data[`OFD_COND_HI:`OFD_COND_LO];
				dec_to_ea <= b8;
				dec_mem_mode <= rm;
				dec_imm <= c_imm;
				dec_illegal <= c_ill;
				dec_ext <= 32'h0000_0000;
			end else if (take_ext) begin
				dec_ext <= (state == ofd_pkg::OFD_ST_EXT_LO && opw[2:0] != `OFD_TRAP_WORD && opw[7:0] != `OFD_DISP_EXT16)
					? {ext_hi, iw_data} : {{16{iw_data[15]}}, iw_data};
			end
		end
	end

	AST_SUBTRACT_QUICK_EIGHT: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && grp == `OFD_GRP_QUICK && !is_trap && qdat == 3'h0 |=> dec_imm == 32'h8)
		else $error("quick subtract zero not eight");
	AST_MOVE_QUICK_SEXT: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && grp == `OFD_GRP_MOVE_QUICK |=> dec_imm == {{24{$past(iw_data[7])}}, $past(iw_data[7:0])})
		else $error("quick move not sign extended");
	AST_BR_EXT32: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && grp == `OFD_GRP_BRANCH && disp8 == `OFD_DISP_EXT32 |=> state == ofd_pkg::OFD_ST_EXT_HI)
		else $error("long branch did not fetch two words");
	AST_BR_EXT16: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && grp == `OFD_GRP_BRANCH && disp8 == `OFD_DISP_EXT16 |=> state == ofd_pkg::OFD_ST_EXT_LO)
		else $error("word branch did not fetch one word");
	AST_TRAP_NONE: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && is_trap && iw_data[2:0] == `OFD_TRAP_NONE |=> dec_valid && dec_op == ofd_pkg::OFD_OP_TRAP)
		else $error("trap without operand not done at once");
	AST_TRAP_BAD: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && is_trap && !trap_ok |=> dec_valid && dec_illegal)
		else $error("bad trap opmode not flagged");
	AST_DIV_KIND: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && grp == `OFD_GRP_OR && opm == 3'h7 |=> dec_op == ofd_pkg::OFD_OP_SIGNED_DIVIDE)
		else $error("signed divide not selected");
	AST_DIV_UNSIGNED: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && grp == `OFD_GRP_OR && opm == 3'h3 |=> dec_op == ofd_pkg::OFD_OP_UNSIGNED_DIVIDE)
		else $error("unsigned divide not selected");
	AST_SIZE_BAD: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && grp == `OFD_GRP_QUICK && !is_trap && sz == `OFD_SIZE_BAD |=> dec_illegal)
		else $error("bad quick size not flagged");
	AST_COMPARE_MEMORY_SIZE: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && c_op == ofd_pkg::OFD_OP_COMPARE_MEMORY |=> dec_size == $past(sz))
		else $error("compare memory size lost");
	AST_SUBTRACT_EXTEND_MEM: assert property (@(posedge ref_clk) disable iff (rst)
		take_op && c_op == ofd_pkg::OFD_OP_SUBTRACT_EXTEND |=> dec_mem_mode == $past(rm))
		else $error("subtract extend mode lost");
endmodule

/* File: testbench/ofd_queue_model.sv */
/*
 Prefetch queue model: hands queued words to the decoder, promptly or with
 an idle cycle before each word.
 Assumes the bench fills it through push and drives slow after a clock edge.
*/
`timescale 1ns/100ps
module ofd_queue_model (
	// clock and reset
	input  wire logic        ref_clk,
	input  wire logic        rst,
	// pacing from the bench
	input  wire logic        slow,
	// decoder side
	input  wire logic        iw_ready,
	output logic             iw_valid,
	output logic [15:0]      iw_data
);
	logic [15:0] words[$];
	logic        gap;
	logic        took;

	task automatic push(input logic [15:0] w);
		words.push_back(w);
	endtask

	initial begin
		iw_valid = 1'b0;
		iw_data = 16'hA5A5;
		gap = 1'b0;
	end

	// a word leaves the queue at an edge that took it or when reset clears the queue; idle data keeps changing
	always @(posedge ref_clk) begin
		took = iw_valid && iw_ready;
		#1;
		if (took && words.size() > 0) void'(words.pop_front());
		if (rst) words.delete();
		if (words.size() > 0 && !(slow && !gap)) begin
			iw_valid = 1'b1;
			iw_data = words[0];
			gap = 1'b0;
		end else begin
			iw_valid = 1'b0;
			iw_data = ~iw_data;
			gap = 1'b1;
		end
	end
endmodule

/* File: testbench/tb_opcode_field_decoder_upper_groups.sv */
/*
 Self-checking bench for the upper-group opcode decoder: a table of opcodes
 with expected decode, then reset, pacing and back-to-back cases.
 Assumes the queue model and the decoder are compiled before it.
*/
`timescale 1ns/100ps
module tb_opcode_field_decoder_upper_groups;
	typedef struct {
		logic [15:0]      w0;
		logic [15:0]      w1;
		logic [15:0]      w2;
		ofd_pkg::ofd_op_e op;
		logic [1:0]       sz;
		logic [31:0]      v;
		logic             imm;
	} ofd_row_s;
	logic             ref_clk;
	logic             rst;
	logic             slow;
	logic             iw_valid;
	logic [15:0]      iw_data;
	logic             iw_ready;
	logic             dec_valid;
	ofd_pkg::ofd_op_e dec_op;
	logic [1:0]       dec_size;
	logic [2:0]       dec_reg_x;
	logic [2:0]       dec_reg_y;
	logic [3:0]       dec_cond;
	logic             dec_to_ea;
	logic             dec_mem_mode;
	logic [31:0]      dec_imm;
	logic [31:0]      dec_ext;
	logic             dec_illegal;
	logic             seen;
	int               n_fail;
	int               n_tests;
	int               cycles;
	// op NONE means the word must be flagged illegal; size 3 means size unchecked
	ofd_row_s rows[34] = '{
		'{16'h50FA, 16'h8001, 16'h0000, ofd_pkg::OFD_OP_TRAP, 2'h3, 32'hFFFF8001, 1'b0},
		'{16'h5AFB, 16'hABCD, 16'h1234, ofd_pkg::OFD_OP_TRAP, 2'h3, 32'hABCD1234, 1'b0},
		'{16'h5FFC, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_TRAP, 2'h3, 32'h00000000, 1'b0},
		'{16'h50FD, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_NONE, 2'h3, 32'h00000000, 1'b0},
		'{16'h5101, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUBTRACT_QUICK, 2'h0, 32'h00000008, 1'b1},
		'{16'h5F40, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUBTRACT_QUICK, 2'h1, 32'h00000007, 1'b1},
		'{16'h5780, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUBTRACT_QUICK, 2'h2, 32'h00000003, 1'b1},
		'{16'h6000, 16'h8000, 16'h0000, ofd_pkg::OFD_OP_BRA, 2'h2, 32'hFFFF8000, 1'b0},
		'{16'h61FF, 16'h1234, 16'h5678, ofd_pkg::OFD_OP_BSR, 2'h2, 32'h12345678, 1'b0},
		'{16'h6700, 16'h7FF0, 16'h0000, ofd_pkg::OFD_OP_BCC, 2'h2, 32'h00007FF0, 1'b0},
		'{16'h7080, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_MOVE_QUICK, 2'h2, 32'hFFFFFF80, 1'b1},
		'{16'h7E7F, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_MOVE_QUICK, 2'h2, 32'h0000007F, 1'b1},
		'{16'h8242, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_OR, 2'h1, 32'h00000000, 1'b0},
		'{16'h80C0, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_UNSIGNED_DIVIDE, 2'h3, 32'h00000000, 1'b0},
		'{16'h81C0, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SIGNED_DIVIDE, 2'h3, 32'h00000000, 1'b0},
		'{16'h8101, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_DECIMAL_SUBTRACT_EXTEND, 2'h0, 32'h00000000, 1'b0},
		'{16'h8109, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_DECIMAL_SUBTRACT_EXTEND, 2'h0, 32'h00000000, 1'b0},
		'{16'h9300, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUBTRACT_EXTEND, 2'h0, 32'h00000000, 1'b0},
		'{16'h9348, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUBTRACT_EXTEND, 2'h1, 32'h00000000, 1'b0},
		'{16'hB000, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_CMP, 2'h0, 32'h00000000, 1'b0},
		'{16'hB108, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_COMPARE_MEMORY, 2'h0, 32'h00000000, 1'b0},
		'{16'hB188, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_COMPARE_MEMORY, 2'h2, 32'h00000000, 1'b0},
		'{16'hC080, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_AND, 2'h2, 32'h00000000, 1'b0},
		'{16'hC0C0, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_NONE, 2'h3, 32'h00000000, 1'b0},
		'{16'h5000, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_NONE, 2'h3, 32'h00000000, 1'b0},
		'{16'h51C0, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_NONE, 2'h3, 32'h00000000, 1'b0},
		'{16'h8141, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_NONE, 2'h3, 32'h00000000, 1'b0},
		'{16'h7100, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_NONE, 2'h3, 32'h00000000, 1'b0},
		'{16'h9042, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUB, 2'h1, 32'h00000000, 1'b0},
		'{16'h90C0, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUBA, 2'h1, 32'h00000000, 1'b0},
		'{16'h9380, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_SUBTRACT_EXTEND, 2'h2, 32'h00000000, 1'b0},
		'{16'hB148, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_COMPARE_MEMORY, 2'h1, 32'h00000000, 1'b0},
		'{16'hB140, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_EOR, 2'h1, 32'h00000000, 1'b0},
		'{16'hB1C0, 16'h0000, 16'h0000, ofd_pkg::OFD_OP_CMPA, 2'h2, 32'h00000000, 1'b0}
	};

	ofd_decoder ofd_decoder_inst (.ref_clk(ref_clk), .rst(rst), .iw_valid(iw_valid), .iw_data(iw_data),
		.iw_ready(iw_ready), .dec_valid(dec_valid), .dec_op(dec_op), .dec_size(dec_size), .dec_reg_x(dec_reg_x),
		.dec_reg_y(dec_reg_y), .dec_cond(dec_cond), .dec_to_ea(dec_to_ea), .dec_mem_mode(dec_mem_mode),
		.dec_imm(dec_imm),
		.dec_ext(dec_ext), .dec_illegal(dec_illegal));
	ofd_queue_model ofd_queue_model_inst (.ref_clk(ref_clk), .rst(rst), .slow(slow), .iw_ready(iw_ready),
		.iw_valid(iw_valid), .iw_data(iw_data));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_tests++;
		if (exp !== got) begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask

	// bounded wait for the decode pulse, sampled after the edge settles
	task automatic wait_dec;
		seen = 1'b0;
		for (int i = 0; i < 12 && !seen; i++) begin
			@(posedge ref_clk);
			#2;
			seen = (dec_valid === 1'b1);
		end
		chk("dec_valid", 32'h1, {31'h0, seen});
	endtask

	task automatic run_row(input ofd_row_s r);
		ofd_queue_model_inst.push(r.w0);
		if (r.w1 !== 16'h0000) ofd_queue_model_inst.push(r.w1);
		if (r.w2 !== 16'h0000) ofd_queue_model_inst.push(r.w2);
		wait_dec();
		chk("dec_illegal", {31'h0, r.op == ofd_pkg::OFD_OP_NONE}, {31'h0, dec_illegal});
		if (r.op != ofd_pkg::OFD_OP_NONE) chk("dec_op", 32'(r.op), 32'(dec_op));
		if (r.sz != 2'h3) chk("dec_size", {30'h0, r.sz}, {30'h0, dec_size});
		chk(r.imm ? "dec_imm" : "dec_ext", r.v, r.imm ? dec_imm : dec_ext);
		if (r.op inside {ofd_pkg::OFD_OP_DECIMAL_SUBTRACT_EXTEND, ofd_pkg::OFD_OP_SUBTRACT_EXTEND, ofd_pkg::OFD_OP_COMPARE_MEMORY}) begin
			chk("dec_mem_mode", {31'h0, r.w0[3]}, {31'h0, dec_mem_mode});
			chk("dec_reg_x", {29'h0, r.w0[11:9]}, {29'h0, dec_reg_x});
			chk("dec_reg_y", {29'h0, r.w0[2:0]}, {29'h0, dec_reg_y});
		end
		if (r.op inside {ofd_pkg::OFD_OP_TRAP, ofd_pkg::OFD_OP_BRA, ofd_pkg::OFD_OP_BSR, ofd_pkg::OFD_OP_BCC})
			chk("dec_cond", {28'h0, r.w0[11:8]}, {28'h0, dec_cond});
		if (r.op != ofd_pkg::OFD_OP_NONE) chk("dec_to_ea", {31'h0, r.w0[8]}, {31'h0, dec_to_ea});
		if (r.op == ofd_pkg::OFD_OP_MOVE_QUICK) chk("dec_reg_x", {29'h0, r.w0[11:9]}, {29'h0, dec_reg_x});
		@(posedge ref_clk);
		#2;
		chk("dec_valid pulse end", 32'h0, {31'h0, dec_valid});
	endtask

	task automatic give_verdict;
		$display("checks %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end

	// hang guard: the whole run needs well under this many cycles
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 3000) begin
			n_fail++;
			$display("unexpected timeout after %0d cycles", cycles);
			give_verdict();
		end
	end

	initial begin
		rst = 1'b1;
		slow = 1'b0;
		repeat (3) @(posedge ref_clk);
		chk("dec_valid in reset", 32'h0, {31'h0, dec_valid});
		chk("dec_op in reset", 32'(ofd_pkg::OFD_OP_NONE), 32'(dec_op));
		#1 rst = 1'b0;
		$display("reset test done");
		foreach (rows[i]) begin
			run_row(rows[i]);
			$display("row %0d done", i);
		end
		// two quick moves back to back must give two adjacent pulses
		ofd_queue_model_inst.push(16'h7080);
		ofd_queue_model_inst.push(16'h7E7F);
		wait_dec();
		chk("dec_imm first", 32'hFFFFFF80, dec_imm);
		@(posedge ref_clk);
		#2;
		chk("dec_valid second", 32'h1, {31'h0, dec_valid});
		chk("dec_imm second", 32'h0000007F, dec_imm);
		$display("back to back test done");
		// gaps between the words of a long displacement are waited out
		@(posedge ref_clk);
		#1 slow = 1'b1;
		run_row(rows[8]);
		#1 slow = 1'b0;
		$display("slow queue test done");
		// reset while a branch waits for its extension; next word is a fresh opcode
		ofd_queue_model_inst.push(16'h6000);
		repeat (2) @(posedge ref_clk);
		#1 rst = 1'b1;
		#1 chk("dec_op after abort", 32'(ofd_pkg::OFD_OP_NONE), 32'(dec_op));
		@(posedge ref_clk);
		#1 rst = 1'b0;
		run_row(rows[10]);
		$display("abort test done");
		give_verdict();
	end
endmodule
